/* File: hw/uart_regs.sv */
// serial port with axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module uart_regs (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [8:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [8:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // serial pins and interrupt request
  input  wire logic        rxd_in,
  output logic             txd_out,
  output logic             txd_oe,
  output logic             irq
);
  typedef enum logic {TX_IDLE, TX_RUN} tx_e;
  typedef enum logic {RX_IDLE, RX_RUN} rx_e;

  logic [7:0] baud_hi, baud_lo, fmt, ctl;
  logic       tx_buffer_empty, tc, rx_buffer_full, idle, ovr, nf, fe, pf;
  logic [7:0] seen, stat;
  logic [8:0] rx_data;
  logic       t8;
  logic       tick;
  // bus
  logic       aw_got, w_got, wr_do, next_aw_got, next_w_got, next_bv, next_rv;
  logic [6:0] aw_idx;
  logic [7:0] w_byte;
  logic       w_lane;
  logic [6:0] ar_idx;
  logic       stat_rd, dat_rd, dat_wr;
  // transmitter
  tx_e        tx_st;
  logic [10:0] tx_sh;
  logic [3:0] tx_ph, tx_cnt, fr_last;
  logic [8:0] tx_buf;
  logic       tx_full, pre_pend, tx_on_q, tx_take, tx_end, tx_line;
  // receiver
  rx_e        rx_st;
  logic       rx_meta, rx_sync, rx_line;
  logic [3:0] rx_ph, rx_cnt;
  logic [2:0] smp;
  logic [8:0] rx_sh;
  logic       rx_nz, maj, rx_done, rx_msb, line_act, idle_ev;
  logic [7:0] idle_cnt, idle_thr;
  logic [8:0] rx_word;

  assign stat = {tx_buffer_empty, tc, rx_buffer_full, idle, ovr, nf, fe, pf};

  uart_baud_tick u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .divisor ({baud_hi[4:0], baud_lo}),
    .tick    (tick)
  );

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  // write performed one edge after both halves are held; bvalid that edge
  assign wr_do       = aw_got & w_got & ~bvalid;
  assign next_aw_got = (aw_got | (awvalid & awready)) & ~wr_do;
  assign next_w_got  = (w_got | (wvalid & wready)) & ~wr_do;
  assign next_bv     = wr_do | (bvalid & ~bready);
  assign next_rv     = (arvalid & arready) | (rvalid & ~rready);
  assign ar_idx      = araddr[8:2];
  assign stat_rd     = arvalid & arready & (ar_idx == uart_pkg::IDX_STAT);
  assign dat_rd      = arvalid & arready & (ar_idx == uart_pkg::IDX_DATA_LO);
  assign dat_wr      = wr_do & w_lane & (aw_idx == uart_pkg::IDX_DATA_LO);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_idx  <= 7'h00;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= uart_pkg::RESP_OKAY;
    end else begin
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      awready <= ~next_aw_got & ~next_bv;
      wready  <= ~next_w_got & ~next_bv;
      bvalid  <= next_bv;
      if (awvalid && awready)
        aw_idx <= awaddr[8:2];
      if (wvalid && wready) begin
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (wr_do)
        bresp <= (aw_idx >= uart_pkg::IDX_BAUD_HI && aw_idx <= uart_pkg::IDX_DATA_LO)
                 ? uart_pkg::RESP_OKAY : uart_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= uart_pkg::RESP_OKAY;
    end else begin
      arready <= ~next_rv;
      rvalid  <= next_rv;
      if (arvalid && arready) begin
        rresp <= uart_pkg::RESP_OKAY;
        unique case (ar_idx)
          uart_pkg::IDX_BAUD_HI: rdata <= {24'h000000, baud_hi};
          uart_pkg::IDX_BAUD_LO: rdata <= {24'h000000, baud_lo};
          uart_pkg::IDX_FMT:     rdata <= {24'h000000, fmt};
          uart_pkg::IDX_CTL:     rdata <= {24'h000000, ctl};
          uart_pkg::IDX_STAT:    rdata <= {24'h000000, stat};
          uart_pkg::IDX_STAT2:   rdata <= {31'h00000000, rx_st == RX_RUN};
          uart_pkg::IDX_DATA_HI: rdata <= {24'h000000, rx_data[8], t8, 6'h00};
          uart_pkg::IDX_DATA_LO: rdata <= {24'h000000, rx_data[7:0]};
          default: begin
            rdata <= 32'h00000000;
            rresp <= uart_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_hi <= uart_pkg::RST_BAUD_HI;
      baud_lo <= uart_pkg::RST_BAUD_LO;
      fmt     <= uart_pkg::RST_CTRL;
      ctl     <= uart_pkg::RST_CTRL;
      t8      <= 1'b0;
    end else begin
      if (wr_do && w_lane) begin
        unique case (aw_idx)
          uart_pkg::IDX_BAUD_HI: baud_hi <= w_byte & uart_pkg::MASK_BIT5;
          uart_pkg::IDX_BAUD_LO: baud_lo <= w_byte;
          uart_pkg::IDX_FMT:     fmt     <= w_byte & uart_pkg::MASK_BIT5;
          uart_pkg::IDX_CTL:     ctl     <= w_byte;
          uart_pkg::IDX_DATA_HI: t8      <= w_byte[uart_pkg::T8_BIT];
          default: ;
        endcase
      end
      // wake by idle line or by msb-one frame; hardware wins
      if ((idle_ev && !fmt[uart_pkg::F_WAKE]) ||
          (rx_done && rx_msb && fmt[uart_pkg::F_WAKE]))
        ctl[uart_pkg::C_SLP] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // status flags and clearing sequence
  // ----------------------------------------------------------------------
  // hardware sets win over the software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {tx_buffer_empty, tc, rx_buffer_full, idle, ovr, nf, fe, pf} <= uart_pkg::RST_STAT;
      seen    <= 8'h00;
      rx_data <= 9'h000;
    end else begin
      if (stat_rd)
        seen <= stat;
      else if (dat_wr)
        seen[7:6] <= 2'b00;
      else if (dat_rd)
        seen[5:0] <= 6'h00;
      if (dat_wr && seen[7]) tx_buffer_empty <= 1'b0;
      if (dat_wr && seen[6]) tc <= 1'b0;
      if (dat_rd) begin
        if (seen[5]) rx_buffer_full <= 1'b0;
        if (seen[4]) idle <= 1'b0;
        if (seen[3]) ovr <= 1'b0;
        if (seen[2]) nf <= 1'b0;
        if (seen[1]) fe <= 1'b0;
        if (seen[0]) pf <= 1'b0;
      end
      if (tx_take) tx_buffer_empty <= 1'b1;
      if (tx_end) tc <= 1'b1;
      if (idle_ev && !ctl[uart_pkg::C_SLP]) idle <= 1'b1;
      // an address frame that wakes the receiver is kept
      if (rx_done && (!ctl[uart_pkg::C_SLP] || (rx_msb && fmt[uart_pkg::F_WAKE]))) begin
        // a data read that ends the clearing sequence in this very cycle frees the buffer for the new character
        if (rx_buffer_full && !(dat_rd && seen[5])) begin
          ovr <= 1'b1;
        end else begin
          rx_buffer_full    <= 1'b1;
          rx_data <= rx_word;
          nf      <= rx_nz;
          fe      <= ~maj;
          pf      <= fmt[uart_pkg::F_PAR] &
                     (uart_pkg::par_bit(rx_word, fmt[uart_pkg::F_ODD]) != 1'b0);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------------
  // frame length minus one: start, 8 or 9 data, stop
  assign fr_last = fmt[uart_pkg::F_NINE] ? uart_pkg::LAST_9 : uart_pkg::LAST_8;
  // break keeps the line low across the idle cycle between frames
  assign tx_line = (tx_st == TX_RUN) ? tx_sh[0] :
                   ~(ctl[uart_pkg::C_BRK] & ctl[uart_pkg::C_TX] & ~pre_pend);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st    <= TX_IDLE;
      tx_sh    <= 11'h7FF;
      tx_ph    <= 4'h0;
      tx_cnt   <= 4'h0;
      tx_buf   <= 9'h000;
      tx_full  <= 1'b0;
      pre_pend <= 1'b0;
      tx_on_q  <= 1'b0;
      tx_take  <= 1'b0;
      tx_end   <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      tx_end  <= 1'b0;
      tx_on_q <= ctl[uart_pkg::C_TX];
      if (ctl[uart_pkg::C_TX] && !tx_on_q)
        pre_pend <= 1'b1;
      if (dat_wr) begin
        tx_buf  <= {t8, w_byte};
        tx_full <= 1'b1;
      end
      unique case (tx_st)
        TX_IDLE: begin
          tx_ph  <= 4'h0;
          tx_cnt <= 4'h0;
          if (!ctl[uart_pkg::C_TX]) begin
            pre_pend <= 1'b0;
            if (tx_full && !dat_wr) begin
              tx_full <= 1'b0;
              tx_take <= 1'b1;
              tx_end  <= 1'b1;
            end
          end else if (pre_pend) begin // idle frame first
            pre_pend <= 1'b0;
            tx_sh    <= 11'h7FF;
            tx_st    <= TX_RUN;
          end else if (ctl[uart_pkg::C_BRK]) begin
            tx_sh <= 11'h000;
            tx_st <= TX_RUN;
          end else if (tx_full && !dat_wr) begin
            tx_full <= 1'b0;
            tx_take <= 1'b1;
            tx_st   <= TX_RUN;
            if (fmt[uart_pkg::F_NINE])
              tx_sh <= {1'b1, fmt[uart_pkg::F_PAR]
                ? {uart_pkg::par_bit({1'b0, tx_buf[7:0]}, fmt[uart_pkg::F_ODD]), tx_buf[7:0]}
                : tx_buf, 1'b0};
            else
              tx_sh <= {2'b11, fmt[uart_pkg::F_PAR]
                ? uart_pkg::par_bit({2'b00, tx_buf[6:0]}, fmt[uart_pkg::F_ODD])
                : tx_buf[7], tx_buf[6:0], 1'b0};
          end
        end
        TX_RUN: begin
          if (tick) begin
            tx_ph <= tx_ph + 4'h1;
            if (tx_ph == uart_pkg::PH_LAST) begin
              tx_sh  <= {1'b1, tx_sh[10:1]}; // lsb first
              tx_cnt <= tx_cnt + 4'h1;
              if (tx_cnt == fr_last) begin
                tx_st  <= TX_IDLE;
                tx_end <= ~tx_full & ~ctl[uart_pkg::C_BRK] & ~pre_pend;
              end
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  // pin released to general use once disabled and idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_out <= 1'b1;
      txd_oe  <= 1'b0;
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rxd_in;
      rx_sync <= rx_meta;
      txd_out <= fmt[uart_pkg::F_LOOP] ? 1'b1 : tx_line;
      if (fmt[uart_pkg::F_OD])
        txd_oe <= (ctl[uart_pkg::C_TX] | (tx_st == TX_RUN)) &
                  ~(fmt[uart_pkg::F_LOOP] | tx_line);
      else
        txd_oe <= ctl[uart_pkg::C_TX] | (tx_st == TX_RUN);
    end
  end

  assign rx_line = fmt[uart_pkg::F_LOOP] ? tx_line : rx_sync;

  // ----------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------
  assign maj      = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);
  assign idle_thr = fmt[uart_pkg::F_NINE] ? uart_pkg::IDLE_9 : uart_pkg::IDLE_8;
  assign rx_word  = fmt[uart_pkg::F_NINE] ? rx_sh : {1'b0, rx_sh[8:1]};
  assign rx_msb   = fmt[uart_pkg::F_NINE] ? rx_sh[8] : rx_sh[8];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st    <= RX_IDLE;
      rx_ph    <= 4'h0;
      rx_cnt   <= 4'h0;
      smp      <= 3'b111;
      rx_sh    <= 9'h000;
      rx_nz    <= 1'b0;
      rx_done  <= 1'b0;
      idle_cnt <= 8'h00;
      line_act <= 1'b0;
      idle_ev  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      idle_ev <= 1'b0;
      if (!ctl[uart_pkg::C_RX]) begin
        rx_st    <= RX_IDLE;
        idle_cnt <= 8'h00;
      end else if (tick) begin
        unique case (rx_st)
          RX_IDLE: begin
            rx_ph  <= 4'h0;
            rx_cnt <= 4'h0;
            rx_nz  <= 1'b0;
            if (!rx_line) begin
              rx_st    <= RX_RUN;
              line_act <= 1'b1;
              idle_cnt <= 8'h00;
            end else if (idle_cnt != idle_thr) begin
              idle_cnt <= idle_cnt + 8'h01;
              if (idle_cnt + 8'h01 == idle_thr && line_act) begin
                idle_ev  <= 1'b1;
                line_act <= 1'b0;
              end
            end
          end
          RX_RUN: begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph >= uart_pkg::PH_S0 && rx_ph <= uart_pkg::PH_S2)
              smp <= {rx_line, smp[2:1]};
            if (rx_ph == uart_pkg::PH_LAST) begin
              rx_cnt <= rx_cnt + 4'h1;
              if (smp != 3'b000 && smp != 3'b111)
                rx_nz <= 1'b1;
              // long mode counts ones only from the stop bit on
              if (!maj || (fmt[uart_pkg::F_ILT] && rx_cnt != fr_last))
                idle_cnt <= 8'h00;
              else if (rx_cnt != 4'h0)
                idle_cnt <= idle_cnt + uart_pkg::BIT_TICKS;
              if (rx_cnt == 4'h0 && maj) begin
                rx_st <= RX_IDLE; // false start
              end else if (rx_cnt == fr_last) begin
                rx_st   <= RX_IDLE;
                rx_done <= 1'b1;
              end else if (rx_cnt != 4'h0) begin
                rx_sh <= {maj, rx_sh[8:1]};
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= (tx_buffer_empty & ctl[uart_pkg::C_TIE]) | (tc & ctl[uart_pkg::C_TX_DONE_IRQ_ON]) |
             (~ctl[uart_pkg::C_SLP] & ((ctl[uart_pkg::C_RIE] & (rx_buffer_full | ovr)) |
              (ctl[uart_pkg::C_IDLE_IRQ_ON] & idle)));
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_div_stop;
    @(posedge aclk) disable iff (!aresetn)
      ({baud_hi[4:0], baud_lo} == 13'h0000) [*2] |-> !tick;
  endproperty
  a_div_stop: assert property (p_div_stop) else $error("tick with zero divisor");

  property p_loop_high;
    @(posedge aclk) disable iff (!aresetn)
      fmt[uart_pkg::F_LOOP] && ctl[uart_pkg::C_TX] |=> txd_out;
  endproperty
  a_loop_high: assert property (p_loop_high) else $error("pin not high in loopback");

  property p_open_drain;
    @(posedge aclk) disable iff (!aresetn)
      $past(fmt[uart_pkg::F_OD]) |-> !(txd_oe && txd_out);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_irq_tx;
    @(posedge aclk) disable iff (!aresetn)
      tx_buffer_empty && ctl[uart_pkg::C_TIE] |=> irq;
  endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("empty interrupt missing");

  property p_irq_rx;
    @(posedge aclk) disable iff (!aresetn)
      !ctl[uart_pkg::C_SLP] && ctl[uart_pkg::C_RIE] && (rx_buffer_full || ovr) |=> irq;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("receive interrupt missing");

  property p_sleep_hold;
    @(posedge aclk) disable iff (!aresetn)
      ctl[uart_pkg::C_SLP] && !rx_buffer_full ##1 ctl[uart_pkg::C_SLP] |-> !rx_buffer_full;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("flag set in sleep");

  property p_tx_buffer_empty_seq;
    @(posedge aclk) disable iff (!aresetn)
      tx_buffer_empty && !seen[7] && !stat_rd && dat_wr |=> tx_buffer_empty;
  endproperty
  a_tx_buffer_empty_seq: assert property (p_tx_buffer_empty_seq) else $error("empty cleared without status read");

  property p_break;
    @(posedge aclk) disable iff (!aresetn)
      tx_st == TX_IDLE && ctl[uart_pkg::C_TX] && ctl[uart_pkg::C_BRK] && !pre_pend
      |=> tx_st == TX_RUN && !tx_line;
  endproperty
  a_break: assert property (p_break) else $error("break not sent");

  c_rx_frame: cover property (@(posedge aclk) disable iff (!aresetn) rx_done && !rx_buffer_full);
  c_tx_done:  cover property (@(posedge aclk) disable iff (!aresetn) tx_end);
  c_wake:     cover property (@(posedge aclk) disable iff (!aresetn)
                              $fell(ctl[uart_pkg::C_SLP]));
endmodule

/* File: hw/uart_pkg.sv */
// constants shared by the serial port register block
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package uart_pkg;
  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_BAUD_HI = 7'h70;
  localparam logic [6:0] IDX_BAUD_LO = 7'h71;
  localparam logic [6:0] IDX_FMT     = 7'h72;
  localparam logic [6:0] IDX_CTL     = 7'h73;
  localparam logic [6:0] IDX_STAT    = 7'h74;
  localparam logic [6:0] IDX_STAT2   = 7'h75;
  localparam logic [6:0] IDX_DATA_HI = 7'h76;
  localparam logic [6:0] IDX_DATA_LO = 7'h77;
  localparam logic [7:0] RST_BAUD_HI = 8'h00;
  localparam logic [7:0] RST_BAUD_LO = 8'h04;
  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam logic [7:0] RST_STAT    = 8'hC0;
  localparam logic [7:0] MASK_BIT5   = 8'hDF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // format control fields
  localparam int F_LOOP = 7;
  localparam int F_OD   = 6;
  localparam int F_NINE = 4;
  localparam int F_WAKE = 3;
  localparam int F_ILT  = 2;
  localparam int F_PAR  = 1;
  localparam int F_ODD  = 0;
  // enable control fields
  localparam int C_TIE  = 7;
  localparam int C_TX_DONE_IRQ_ON = 6;
  localparam int C_RIE  = 5;
  localparam int C_IDLE_IRQ_ON = 4;
  localparam int C_TX   = 3;
  localparam int C_RX   = 2;
  localparam int C_SLP  = 1;
  localparam int C_BRK  = 0;
  localparam int T8_BIT = 6;
  // oversampling: ticks per bit and majority sample points
  localparam logic [3:0] PH_LAST = 4'hF;
  localparam logic [3:0] PH_S0   = 4'h7;
  localparam logic [3:0] PH_S2   = 4'h9;
  // frame length minus one, idle threshold in ticks, ticks per bit
  localparam logic [3:0] LAST_8    = 4'h9;
  localparam logic [3:0] LAST_9    = 4'hA;
  localparam logic [7:0] IDLE_8    = 8'hA0;
  localparam logic [7:0] IDLE_9    = 8'hB0;
  localparam logic [7:0] BIT_TICKS = 8'h10;

  // parity bit for a data word; odd select yields zero on odd ones
  function automatic logic par_bit(input logic [8:0] d, input logic odd);
    par_bit = ^d ^ odd;
  endfunction
endpackage

/* File: hw/uart_baud_tick.sv */
// oversampling tick generator: one tick per 2 x divisor clocks
`timescale 1ns/10ps
module uart_baud_tick (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // divisor and tick
  input  wire logic [12:0] divisor,
  output logic             tick
);
  logic [13:0] cnt;
  logic [13:0] last;

  assign last = {divisor, 1'b0} - 14'h0001;

  // ----------------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= 14'h0000;
      tick <= 1'b0;
    end else if (divisor == 13'h0000) begin
      cnt  <= 14'h0000;
      tick <= 1'b0;
    end else if (cnt >= last) begin
      cnt  <= 14'h0000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 14'h0001;
      tick <= 1'b0;
    end
  end
endmodule

/* File: tb/serial_node.sv */
// remote serial node model: frame sender and frame catcher
`timescale 1ns/10ps
module serial_node #(
  parameter int BIT = 32
) (
  // clock
  input  wire logic       aclk,
  // sender side
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_go,
  output logic            line,
  // catcher side
  input  wire logic       txd,
  output logic [7:0]      got,
  output int              got_cnt
);
  // --------------------------------------------------------------
  // sender holds the line high between frames
  // --------------------------------------------------------------
  initial line = 1'b1;
  always @(posedge aclk) begin
    if (tx_go) begin
      line <= 1'b0;
      repeat (BIT) @(posedge aclk);
      for (int k = 0; k < 8; k++) begin
        line <= tx_byte[k];
        repeat (BIT) @(posedge aclk);
      end
      line <= 1'b1;
      repeat (BIT) @(posedge aclk);
    end
  end
  // mid-bit sampling, since frames are not aligned to bit boundaries
  initial got_cnt = 0;
  always begin
    @(negedge txd);
    repeat (BIT + BIT / 2) @(posedge aclk);
    for (int k = 0; k < 8; k++) begin
      got[k] = txd;
      repeat (BIT) @(posedge aclk);
    end
    got_cnt++;
  end
endmodule

/* File: tb/async_serial_port_regs_test.sv */
// bench for the serial port register block
`timescale 1ns/10ps
module async_serial_port_regs_test;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [8:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rxd_in, txd_out, txd_oe, irq, tx_go;
  logic [1:0] bresp, rresp, r;
  logic [7:0] tx_byte, got;
  logic [7:0] rv [5] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'hC0};
  int got_cnt;
  int err_count = 0;
  int num_checks = 0;
  // open-drain style pin idles high through its pull-up when released
  wire pin = txd_oe ? txd_out : 1'b1;
  always #20 aclk = ~aclk;
  uart_regs u_uart_regs (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rxd_in(rxd_in),
    .txd_out(txd_out), .txd_oe(txd_oe), .irq(irq));
  serial_node u_serial_node (.aclk(aclk), .tx_byte(tx_byte), .tx_go(tx_go), .line(rxd_in),
    .txd(pin), .got(got), .got_cnt(got_cnt));
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] i);
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge aclk);
    tx_byte <= b;
    tx_go <= 1'b1;
    @(posedge aclk);
    tx_go <= 1'b0;
    repeat (360) @(posedge aclk);
  endtask
  task automatic results;
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, tx_go} = '0;
    {awaddr, araddr, wdata, tx_byte} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      rd(uart_pkg::IDX_BAUD_HI + 7'(k));
      chk(v, {24'h0, rv[k]});
    end
    rd(7'h10);
    chk({30'h0, r}, {30'h0, uart_pkg::RESP_SLVERR});
    wr(7'h10, 8'h00);
    chk({30'h0, r}, {30'h0, uart_pkg::RESP_SLVERR});
    wr(uart_pkg::IDX_BAUD_LO, 8'h01);
    chk({30'h0, r}, {30'h0, uart_pkg::RESP_OKAY});
    wr(uart_pkg::IDX_CTL, 8'h2C);
    for (int n = 0; n < 200 && v[6] !== 1'b1; n++) rd(uart_pkg::IDX_STAT);
    chk(v & 32'hC0, 32'hC0);
    wr(uart_pkg::IDX_DATA_LO, 8'hA5);
    rd(uart_pkg::IDX_STAT);
    chk(v & 32'h40, 32'h00);
    for (int n = 0; n < 1000 && got_cnt == 0; n++) @(posedge aclk);
    chk({24'h0, got}, 32'hA5);
    chk({31'h0, txd_oe}, 32'h1);
    send(8'h3C);
    chk({31'h0, irq}, 32'h1);
    rd(uart_pkg::IDX_STAT);
    chk(v & 32'h2F, 32'h20);
    rd(uart_pkg::IDX_DATA_LO);
    chk(v, 32'h3C);
    rd(uart_pkg::IDX_STAT);
    chk({v[5], irq}, 32'h0);
    send(8'h11);
    send(8'h22);
    rd(uart_pkg::IDX_STAT);
    chk(v & 32'h28, 32'h28);
    rd(uart_pkg::IDX_DATA_LO);
    chk(v, 32'h11);
    rd(uart_pkg::IDX_STAT);
    chk(v & 32'h28, 32'h00);
    wr(uart_pkg::IDX_FMT, 8'h80);
    wr(uart_pkg::IDX_DATA_LO, 8'h5A);
    repeat (400) @(posedge aclk);
    chk(got_cnt, 1);
    rd(uart_pkg::IDX_STAT);
    chk(v & 32'h20, 32'h20);
    rd(uart_pkg::IDX_DATA_LO);
    chk(v, 32'h5A);
    wr(uart_pkg::IDX_FMT, 8'h90);
    wr(uart_pkg::IDX_DATA_HI, 8'h40);
    wr(uart_pkg::IDX_DATA_LO, 8'h3C);
    repeat (400) @(posedge aclk);
    rd(uart_pkg::IDX_STAT);
    rd(uart_pkg::IDX_DATA_HI);
    chk(v, 32'hC0);
    rd(uart_pkg::IDX_DATA_LO);
    chk(v, 32'h3C);
    // odd parity: an even count of ones in the low seven bits sends a one
    wr(uart_pkg::IDX_FMT, 8'h83);
    wr(uart_pkg::IDX_DATA_LO, 8'h03);
    repeat (400) @(posedge aclk);
    rd(uart_pkg::IDX_STAT);
    chk(v & 32'h27, 32'h20);
    rd(uart_pkg::IDX_DATA_LO);
    chk(v, 32'h83);
    wr(uart_pkg::IDX_FMT, 8'h43);
    send(8'h03);
    rd(uart_pkg::IDX_STAT);
    chk(v & 32'h27, 32'h21);
    rd(uart_pkg::IDX_DATA_LO);
    chk(v, 32'h03);
    wr(uart_pkg::IDX_DATA_LO, 8'h55);
    for (int n = 0; n < 1000 && got_cnt < 2; n++) @(posedge aclk);
    chk({24'h0, got}, 32'hD5);
    chk({31'h0, txd_oe}, 32'h0);
    wr(uart_pkg::IDX_FMT, 8'h88);
    wr(uart_pkg::IDX_CTL, 8'h2E);
    wr(uart_pkg::IDX_DATA_LO, 8'h11);
    repeat (400) @(posedge aclk);
    rd(uart_pkg::IDX_STAT);
    chk(v & 32'h20, 32'h00);
    wr(uart_pkg::IDX_DATA_LO, 8'h81);
    repeat (400) @(posedge aclk);
    rd(uart_pkg::IDX_CTL);
    chk(v, 32'h2C);
    rd(uart_pkg::IDX_STAT);
    rd(uart_pkg::IDX_DATA_LO);
    chk(v, 32'h81);
    wr(uart_pkg::IDX_FMT, 8'h00);
    wr(uart_pkg::IDX_CTL, 8'h2D);
    repeat (100) @(posedge aclk);
    chk({31'h0, pin}, 32'h0);
    results();
  end
  // a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    results();
  end
endmodule
